// *** design/tce_pkg.sv ***
package tce_pkg;
    localparam int NumChan = 3;
    localparam int RegW = 16;
    localparam int AddrW = 4;
    // Register indices
    localparam logic [AddrW-1:0] AddrCtl0 = 4'h0;
    localparam logic [AddrW-1:0] AddrCtl1 = 4'h1;
    localparam logic [AddrW-1:0] AddrCtl2 = 4'h2;
    localparam logic [AddrW-1:0] AddrStat = 4'h3;
    localparam logic [AddrW-1:0] AddrIrqStat = 4'h4;
    localparam logic [AddrW-1:0] AddrIrqMask = 4'h5;
    // Control register fields
    localparam int BitEnable = 15;
    localparam int BitPinDrive = 14;
    localparam int BitInvert = 13;
    localparam int BitEvent = 9;
    localparam int BitResult = 8;
    localparam int BitEdgeHi = 7;
    localparam int BitEdgeLo = 6;
    localparam int BitPlusSel = 4;
    localparam int BitMinusHi = 1;
    localparam int BitMinusLo = 0;
    // Status register fields
    localparam int BitIdleSup = 15;
    localparam int BitEvtMirror = 8;
    localparam int BitResMirror = 0;
    // Edge select codes
    localparam logic [1:0] EdgeOff = 2'h0;
    localparam logic [1:0] EdgeRise = 2'h1;
    localparam logic [1:0] EdgeFall = 2'h2;
    localparam logic [1:0] EdgeAny = 2'h3;
    localparam logic [RegW-1:0] RegZero = 16'h0000;
    localparam logic [2:0] ChanZero = 3'h0;
    typedef struct packed {
        logic [1:0] edgeSel;
        logic plusSel;
        logic [1:0] minusSel;
        logic enable;
        logic pinDrive;
        logic invert;
        logic eventLatched;
    } tce_chan_type;
endpackage : tce_pkg

// *** design/tce_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Carries raw and synchronised comparator results
interface tce_sync_if;
    logic [2:0] raw;
    logic [2:0] synced;
    modport producer (input raw, output synced);
    modport consumer (output raw, input synced);
endinterface : tce_sync_if
`default_nettype wire

// *** design/tce_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for the analog results
module tce_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    tce_sync_if.producer sy
);
    import tce_pkg::*;
    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } tce_sync_st_type;
    tce_sync_st_type st_r;
    tce_sync_st_type st_nxt;
    // Next state
    always_comb
    begin
        st_nxt.stage1 = sy.raw;
        st_nxt.stage2 = st_r.stage1;
    end
    // Registers
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign sy.synced = st_r.stage2;
endmodule : tce_sync
`default_nettype wire

// *** design/tce_comparator.sv ***
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tce_comparator (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [tce_pkg::AddrW-1:0] regAddr,
    input wire logic [tce_pkg::RegW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [tce_pkg::RegW-1:0] regRdata,
    input wire logic [2:0] analogResult,
    input wire logic idleMode,
    output logic [2:0] comparatorEnable,
    output logic [2:0] plusInputSelect,
    output logic [5:0] minusInputSelect,
    output logic [2:0] resultPinOut,
    output logic [2:0] resultPinOeN,
    output logic [2:0] eventTrigger,
    output logic irq
);
    import tce_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        tce_chan_type [NumChan-1:0] chan;
        logic idleSup;
        logic [2:0] prevOut;
        logic [2:0] trig;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        logic [RegW-1:0] rdata;
    } tce_state_type;

    tce_state_type st_r;
    tce_state_type st_nxt;
    logic [2:0] syncRes;
    logic [2:0] resultBit;
    logic [2:0] evtHit;
    logic [2:0] rawRes;

    tce_sync_if syIf ();
    assign syIf.raw = analogResult;
    assign syncRes = syIf.synced;

    // Synchroniser for analog results
    tce_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sy(syIf.producer)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Build the readable control word of one channel
    function automatic logic [RegW-1:0] ctlWord(input tce_chan_type c, input logic res);
        logic [RegW-1:0] w;
        w = RegZero;
        w[BitEnable] = c.enable;
        w[BitPinDrive] = c.pinDrive;
        w[BitInvert] = c.invert;
        w[BitEvent] = c.eventLatched;
        w[BitResult] = res;
        w[BitEdgeHi:BitEdgeLo] = c.edgeSel;
        w[BitPlusSel] = c.plusSel;
        w[BitMinusHi:BitMinusLo] = c.minusSel;
        return w;
    endfunction : ctlWord

    // Decode an edge select against raw result edges, taken before inversion
    function automatic logic edgeMatch(input logic [1:0] sel, input logic prev, input logic cur);
        logic hit;
        case (sel)
            EdgeAny: hit = prev != cur;
            EdgeFall: hit = prev & ~cur;
            EdgeRise: hit = ~prev & cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edgeMatch

    // ----------------------------------------
    // Per channel result and event detect
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NumChan; gi++)
        begin : g_chan
            // Inverted result; a disabled comparator reads low before inversion
            assign resultBit[gi] = (syncRes[gi] & st_r.chan[gi].enable) ^ st_r.chan[gi].invert;
            // Level before inversion, so a polarity write alone is no edge
            assign rawRes[gi] = resultBit[gi] ^ st_r.chan[gi].invert;
            // Raw edges; inversion swaps the edge direction seen on the result
            assign evtHit[gi] = st_r.chan[gi].enable & ~st_r.chan[gi].eventLatched
                & edgeMatch(st_r.chan[gi].edgeSel, st_r.prevOut[gi], rawRes[gi]);
            // Raw pin output, not synchronised
            assign resultPinOut[gi] = (analogResult[gi] & st_r.chan[gi].enable) ^ st_r.chan[gi].invert;
            assign resultPinOeN[gi] = ~(st_r.chan[gi].enable & st_r.chan[gi].pinDrive);
            assign comparatorEnable[gi] = st_r.chan[gi].enable;
            assign plusInputSelect[gi] = st_r.chan[gi].plusSel;
            assign minusInputSelect[2*gi+1 -: 2] = st_r.chan[gi].minusSel;
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Register writes, event latching and read data
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.trig = ChanZero;
        st_nxt.rdata = RegZero;
        for (int i = 0; i < NumChan; i++)
        begin
            st_nxt.prevOut[i] = rawRes[i];
            if (regWrite && regAddr == AddrCtl0 + AddrW'(i))
            begin
                st_nxt.chan[i].enable = regWdata[BitEnable];
                st_nxt.chan[i].pinDrive = regWdata[BitPinDrive];
                st_nxt.chan[i].invert = regWdata[BitInvert];
                st_nxt.chan[i].eventLatched = regWdata[BitEvent];
                st_nxt.chan[i].edgeSel = regWdata[BitEdgeHi:BitEdgeLo];
                st_nxt.chan[i].plusSel = regWdata[BitPlusSel];
                st_nxt.chan[i].minusSel = regWdata[BitMinusHi:BitMinusLo];
            end
            // Hardware set wins over a software clear
            if (evtHit[i])
            begin
                st_nxt.chan[i].eventLatched = 1'b1;
                st_nxt.trig[i] = 1'b1;
                if (!(st_r.idleSup && idleMode))
                begin
                    st_nxt.irqStat[i] = 1'b1;
                end
            end
        end
        if (regWrite && regAddr == AddrStat)
        begin
            st_nxt.idleSup = regWdata[BitIdleSup];
        end
        if (regWrite && regAddr == AddrIrqMask)
        begin
            st_nxt.irqMask = regWdata[NumChan-1:0];
        end
        if (regRead)
        begin
            case (regAddr)
                AddrCtl0: st_nxt.rdata = ctlWord(st_r.chan[0], resultBit[0]);
                AddrCtl1: st_nxt.rdata = ctlWord(st_r.chan[1], resultBit[1]);
                AddrCtl2: st_nxt.rdata = ctlWord(st_r.chan[2], resultBit[2]);
                AddrStat:
                begin
                    st_nxt.rdata[BitIdleSup] = st_r.idleSup;
                    st_nxt.rdata[BitEvtMirror +: 3] = {st_r.chan[2].eventLatched,
                        st_r.chan[1].eventLatched, st_r.chan[0].eventLatched};
                    st_nxt.rdata[BitResMirror +: 3] = resultBit;
                end
                AddrIrqStat:
                begin
                    st_nxt.rdata[NumChan-1:0] = st_r.irqStat;
                    // Read clears, except bits set this cycle
                    for (int j = 0; j < NumChan; j++)
                    begin
                        st_nxt.irqStat[j] = evtHit[j] & ~(st_r.idleSup & idleMode);
                    end
                end
                AddrIrqMask: st_nxt.rdata[NumChan-1:0] = st_r.irqMask;
                default: st_nxt.rdata = RegZero;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // State register, all zero at reset
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign regRdata = st_r.rdata;
    assign eventTrigger = st_r.trig;
    assign irq = |(st_r.irqStat & st_r.irqMask);
endmodule : tce_comparator
`default_nettype wire

// *** bench/tce_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tce_analog_model #(
    parameter int SettleNs = 3
) (
    input wire logic [2:0] level,
    output wire logic [2:0] analogResult
);
    // Results settle off the clock grid; unknown until SettleNs after time zero
    assign #(SettleNs) analogResult = level;
endmodule : tce_analog_model
`default_nettype wire

// *** bench/tce_comparator_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tce_comparator_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [tce_pkg::AddrW-1:0] regAddr,
    input wire logic [tce_pkg::RegW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [tce_pkg::RegW-1:0] regRdata,
    input wire logic [2:0] analogResult,
    input wire logic [2:0] comparatorEnable,
    input wire logic [2:0] plusInputSelect,
    input wire logic [5:0] minusInputSelect,
    input wire logic [2:0] resultPinOut,
    input wire logic [2:0] resultPinOeN,
    input wire logic [2:0] eventTrigger,
    input wire logic irq
);
    import tce_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_rdIdle; !$past(regRead) |-> regRdata == RegZero; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside read");
    property p_rdUnmap; $past(regRead && regAddr > AddrIrqMask) |-> regRdata == RegZero; endproperty
    a_rdUnmap: assert property (p_rdUnmap) else $error("unmapped read not zero");
    property p_rdCtl; $past(regRead && regAddr < AddrStat) |-> (regRdata & 16'h1C2C) == RegZero; endproperty
    a_rdCtl: assert property (p_rdCtl) else $error("control hole not zero");
    property p_rdStat; $past(regRead && regAddr == AddrStat) |-> (regRdata & 16'h78F8) == RegZero; endproperty
    a_rdStat: assert property (p_rdStat) else $error("status hole not zero");
    property p_enWr; $past(regWrite && regAddr == AddrCtl0) |-> comparatorEnable[0] == $past(regWdata[15]);
    endproperty
    a_enWr: assert property (p_enWr) else $error("enable not written");
    property p_selWr; $past(regWrite && regAddr == AddrCtl1) |-> plusInputSelect[1] == $past(regWdata[4])
        && minusInputSelect[3:2] == $past(regWdata[1:0]); endproperty
    a_selWr: assert property (p_selWr) else $error("input selects not written");
    property p_oe; (resultPinOeN | comparatorEnable) == 3'h7; endproperty
    a_oe: assert property (p_oe) else $error("pin driven while disabled");
    property p_pinRaw; comparatorEnable[0] && $stable(comparatorEnable[0]) && !$past(regWrite)
        && $changed(analogResult[0]) |-> $changed(resultPinOut[0]); endproperty
    a_pinRaw: assert property (p_pinRaw) else $error("pin not following result");
    property p_trig; |eventTrigger |=> (eventTrigger & $past(eventTrigger)) == 3'h0; endproperty
    a_trig: assert property (p_trig) else $error("event repeated while latched");
    property p_irq; $rose(irq) |-> (|eventTrigger) || $past(regWrite && regAddr == AddrIrqMask); endproperty
    a_irq: assert property (p_irq) else $error("irq without event");
endmodule : tce_comparator_asserts
bind tce_comparator tce_comparator_asserts i_tce_comparator_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .analogResult(analogResult), .comparatorEnable(comparatorEnable), .plusInputSelect(plusInputSelect),
    .minusInputSelect(minusInputSelect), .resultPinOut(resultPinOut), .resultPinOeN(resultPinOeN),
    .eventTrigger(eventTrigger), .irq(irq));
`default_nettype wire

// *** bench/tce_comparator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tce_comparator_tb_top;
    import tce_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic regWrite = 1'b0, regRead = 1'b0, idleMode = 1'b0, irq;
    logic [AddrW-1:0] regAddr = 4'h0;
    logic [RegW-1:0] regWdata = 16'h0000, regRdata, rise, fall, ctl;
    logic [2:0] level = 3'h0, analogResult, comparatorEnable, plusInputSelect;
    logic [2:0] resultPinOut, resultPinOeN, eventTrigger;
    logic [5:0] minusInputSelect;
    int miscompares = 0, checked = 0, trigCnt = 0, cycles = 0, base;
    tce_analog_model i_tce_analog_model (.level(level), .analogResult(analogResult));
    tce_comparator i_tce_comparator (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .analogResult(analogResult), .idleMode(idleMode), .comparatorEnable(comparatorEnable),
        .plusInputSelect(plusInputSelect), .minusInputSelect(minusInputSelect), .resultPinOut(resultPinOut),
        .resultPinOeN(resultPinOeN), .eventTrigger(eventTrigger), .irq(irq));
    // Clock
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Event pulse count and hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (eventTrigger[0] === 1'b1) trigCnt <= trigCnt + 1;
        if (cycles == 4000)
        begin
            miscompares = miscompares + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [RegW-1:0] exp, input logic [RegW-1:0] got);
        checked = checked + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [AddrW-1:0] a, input logic [RegW-1:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AddrW-1:0] a, input logic [RegW-1:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk($sformatf("register %h", a), exp, regRdata);
    endtask : rd
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(i[3:0], RegZero);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            wr(i[3:0], 16'hFFFF);
            rd(i[3:0], 16'hE3D3);
        end
        chk("outputs", 16'hFFF0, {comparatorEnable, plusInputSelect, minusInputSelect, resultPinOeN, 1'b0});
        chk("pins", 16'h0007, {13'h0, resultPinOut});
        wr(AddrCtl1, RegZero);
        wr(AddrCtl2, RegZero);
        wr(AddrStat, 16'hFFFF);
        rd(AddrStat, 16'h8101);
        wr(AddrStat, RegZero);
        wr(AddrIrqMask, 16'h0007);
        $display("test layout done");
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 2; p++)
            begin
                ctl = 16'(16'h8000 | (p << 13));
                wr(AddrCtl0, ctl);
                repeat (6) @(posedge clk_sys);
                wr(AddrCtl0, ctl | 16'(c << 6));
                base = trigCnt;
                @(posedge clk_sys); // Quiet cycle after the write for the pin check
                level[0] <= 1'b1;
                repeat (8) @(posedge clk_sys);
                #1;
                rise = 16'(c % 2);
                chk("rise events", rise, 16'(trigCnt - base));
                chk("irq", rise, {15'h0, irq});
                rd(AddrStat, 16'((rise << 8) | (1 - p)));
                rd(AddrIrqStat, rise);
                wr(AddrCtl0, ctl | 16'(c << 6));
                base = trigCnt;
                @(posedge clk_sys); // Quiet cycle after the write for the pin check
                level[0] <= 1'b0;
                repeat (8) @(posedge clk_sys);
                #1;
                fall = 16'(c / 2);
                chk("fall events", fall, 16'(trigCnt - base));
                rd(AddrIrqStat, fall);
            end
        $display("test edges done");
        wr(AddrStat, 16'h8000);
        idleMode <= 1'b1;
        wr(AddrCtl0, 16'h80C0);
        @(posedge clk_sys); // Quiet cycle after the write for the pin check
        level[0] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("idle irq", RegZero, {15'h0, irq});
        rd(AddrStat, 16'h8101);
        rd(AddrIrqStat, RegZero);
        $display("test idle done");
        summarize();
    end
endmodule : tce_comparator_tb_top
`default_nettype wire
